// >>> verilog/lbcsr_pkg.sv
// Purpose: Shared constants and types for the logic block routing core.
// Assumes: One system clock; all routing inputs synchronous to it.
// Notes:   Code values here are used by lbcsr_top through names, except SUB_PTA0 and SUB_PTA1, which it indexes as 0 and 1.
package lbcsr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int DP_IO      = 6;   // Datapath routing inputs and outputs.
  localparam int CFG_DEPTH  = 8;   // Stored datapath configurations.
  localparam int CFG_AW     = 3;
  localparam int FIFO_DEPTH = 4;   // Bytes per datapath FIFO.
  localparam int FIFO_AW    = 2;
  localparam int ROUTE_W    = 8;   // Routing wires into the block.
  localparam int POOL_SELW  = 4;   // Select width into the signal pool.
  localparam int PIN_N      = 8;   // Pins per I/O port.
  localparam int OE_N       = 4;   // Output enable routes per port.
  localparam int SUB_N      = 4;   // Clocked subcomponents.

  // Subcomponent indices.
  localparam int SUB_PTA0 = 0;
  localparam int SUB_PTA1 = 1;
  localparam int SUB_DP   = 2;
  localparam int SUB_SC   = 3;

  // Values after reset.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] REG_RST  = 8'h00;

  // ALU operations.
  localparam logic [2:0] ALU_PASS = 3'h0;
  localparam logic [2:0] ALU_INC  = 3'h1;
  localparam logic [2:0] ALU_DEC  = 3'h2;
  localparam logic [2:0] ALU_ADD  = 3'h3;
  localparam logic [2:0] ALU_SUB  = 3'h4;
  localparam logic [2:0] ALU_AND  = 3'h5;
  localparam logic [2:0] ALU_OR   = 3'h6;
  localparam logic [2:0] ALU_XOR  = 3'h7;

  // Shifter operations.
  localparam logic [1:0] SH_NONE  = 2'h0;
  localparam logic [1:0] SH_LEFT  = 2'h1;
  localparam logic [1:0] SH_RIGHT = 2'h2;
  localparam logic [1:0] SH_SWAP  = 2'h3;

  // Carry and shift-in sources.
  localparam logic [1:0] SRC_ZERO  = 2'h0;
  localparam logic [1:0] SRC_ROUTE = 2'h1;
  localparam logic [1:0] SRC_CHAIN = 2'h2;
  localparam logic [1:0] SRC_REG   = 2'h3;

  // Subcomponent clock enable modes.
  localparam logic [1:0] EN_STOP  = 2'h0;
  localparam logic [1:0] EN_RUN   = 2'h1;
  localparam logic [1:0] EN_CTRL  = 2'h2;
  localparam logic [1:0] EN_ROUTE = 2'h3;

  // Output enable grouping modes.
  localparam logic [1:0] OE_GANG8 = 2'h0;
  localparam logic [1:0] OE_PAIRS = 2'h1;
  localparam logic [1:0] OE_FOUR  = 2'h2;
  localparam logic [1:0] OE_NONE  = 2'h3;

  // One stored datapath configuration word.
  typedef struct packed {
    logic [3:0] spare;
    logic       fifoXfer;
    logic       accWr;
    logic       regSet;
    logic [1:0] shiftSrc;
    logic [1:0] carrySrc;
    logic [1:0] shiftOp;
    logic [2:0] aluOp;
  } lbcsr_cfg_t;

  // Signals passed to and from a neighbouring datapath.
  typedef struct packed {
    logic cond;
    logic carry;
    logic shift;
  } lbcsr_chain_t;

endpackage

// >>> verilog/lbcsr_top.sv
// Purpose: Control, status, datapath and pin routing of one logic block.
// Assumes: Pins and routing inputs are synchronous to clk.
// Notes:   Pin bypass paths are combinational by design.
`timescale 1ns/10ps
`default_nettype none

module lbcsr_top
  import lbcsr_pkg::*;
#(
  parameter int NREQ = 4
) (
  input  wire logic                          clk,         // System clock.
  input  wire logic                          rst,         // Sync reset.
  input  wire logic                          ctrlWrEn,    // Control write.
  input  wire logic [7:0]                    ctrlWrData,  // Control data.
  input  wire logic [7:0]                    ctrlRouteEn, // Bit routed.
  output logic      [7:0]                    ctrlOut,     // To routing.
  input  wire logic                          stsRdEn,     // Status read.
  input  wire logic [7:0]                    stsSticky,   // Hold mode.
  input  wire logic [7:0][POOL_SELW-1:0]     stsSel,      // Bit source.
  output logic      [7:0]                    stsRdData,   // Read value.
  input  wire logic [ROUTE_W-1:0]            routeIn,     // Routing in.
  input  wire logic                          cfgWrEn,     // Config write.
  input  wire logic [CFG_AW-1:0]             cfgWrAddr,   // Config slot.
  input  wire lbcsr_pkg::lbcsr_cfg_t         cfgWrData,   // Config word.
  input  wire logic [DP_IO-1:0]              dpIn,        // Datapath in.
  input  wire logic [DP_IO-1:0][2:0]         dpOutSel,    // Out choice.
  output logic      [DP_IO-1:0]              dpOut,       // Datapath out.
  input  wire lbcsr_pkg::lbcsr_chain_t       chainIn,     // From below.
  output lbcsr_pkg::lbcsr_chain_t            chainOut,    // To above.
  input  wire logic [1:0]                    fifoDirOut,  // 1: output.
  input  wire logic [1:0]                    fifoWr,      // Bus push.
  input  wire logic [7:0]                    fifoWrData,  // Bus data.
  input  wire logic [1:0]                    fifoRd,      // Bus pop.
  output logic      [1:0][7:0]               fifoRdData,  // Popped byte.
  output logic      [1:0][FIFO_AW:0]         fifoLevel,   // Fill level.
  input  wire logic [SUB_N-1:0][1:0]         subEnMode,   // Enable mode.
  input  wire logic [1:0][1:0][ROUTE_W-1:0]  ptaMask,     // Term inputs.
  output logic      [1:0]                    ptaOut,      // Array out.
  input  wire logic [NREQ-1:0][POOL_SELW-1:0] irqSel,     // IRQ source.
  output logic      [NREQ-1:0]               irqReq,      // IRQ lines.
  input  wire logic [NREQ-1:0][POOL_SELW-1:0] dmaSel,     // DMA source.
  output logic      [NREQ-1:0]               dmaReq,      // DMA lines.
  input  wire logic [PIN_N-1:0]              ioOutRoute,  // Pin data.
  input  wire logic [OE_N-1:0]               ioOeRoute,   // Enables.
  output logic      [PIN_N-1:0]              ioInRoute,   // Pin reads.
  input  wire logic [PIN_N-1:0]              ioOutSyncEn, // Out stage.
  input  wire logic [PIN_N-1:0]              ioInSyncEn,  // In stages.
  input  wire logic [1:0]                    oeMode,      // Grouping.
  input  wire logic [PIN_N-1:0]              pinIn,       // Pin level.
  output logic      [PIN_N-1:0]              pinOut,      // Pin drive.
  output logic      [PIN_N-1:0]              pinOeN       // Low drives.
);

  import lbcsr_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [SUB_N-1:0]         subRun;
  logic [15:0]              pool;
  logic [7:0]               ctrlReg_r;
  logic [7:0]               stsIn;
  logic [7:0]               stsHold_r;
  lbcsr_cfg_t               cfgRam_r [CFG_DEPTH];
  lbcsr_cfg_t               cfg;
  logic [1:0][7:0]          acc_r;
  logic [1:0][7:0]          data_r;
  logic [1:0]               carryReg_r;
  logic [1:0]               shiftReg_r;
  logic                     set;
  logic                     cin;
  logic                     sin;
  logic [8:0]               alu;
  logic [7:0]               shRes;
  logic                     sout;
  logic [7:0]               condVec;
  logic [1:0][7:0]          fifoHead;
  logic [1:0]               dpPush;
  logic [1:0]               dpPop;
  logic [1:0]               fEmpty;
  logic [1:0]               fFull;

  // Signal pool that status bits and request lines may pick from.
  assign pool = {ptaOut, dpOut, routeIn};

  // ****************************************
  // Subcomponent enables
  // ****************************************
  // Each subcomponent chooses its own run condition.
  always_comb begin
    for (int s = 0; s < SUB_N; s++) begin
      unique case (subEnMode[s])
        EN_STOP:  subRun[s] = 1'b0;
        EN_RUN:   subRun[s] = 1'b1;
        EN_CTRL:  subRun[s] = ctrlOut[s];
        EN_ROUTE: subRun[s] = routeIn[s];
      endcase
    end
  end

  // ****************************************
  // Control and status
  // ****************************************
  // Firmware writes land in the control register at once.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlReg_r <= CTRL_RST;
    end else if (ctrlWrEn) begin
      ctrlReg_r <= ctrlWrData;
    end
  end

  // Each control bit reaches routing only where its route is made.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlOut <= CTRL_RST;
    end else if (subRun[SUB_SC]) begin
      ctrlOut <= ctrlReg_r & ctrlRouteEn;
    end
  end

  // Each status bit takes its own routed source.
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      stsIn[b] = pool[stsSel[b]];
    end
  end

  // Sticky bits latch events; a new event beats the read clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      stsHold_r <= REG_RST;
    end else if (subRun[SUB_SC]) begin
      stsHold_r <= stsSticky &
                   (stsIn | (stsHold_r & ~{8{stsRdEn}}));
    end
  end

  // Reads return live routing or the held value; nothing is writable.
  always_ff @(posedge clk) begin
    if (rst) begin
      stsRdData <= REG_RST;
    end else if (stsRdEn) begin
      stsRdData <= stsIn | (stsHold_r & stsSticky);
    end
  end

  // ****************************************
  // Datapath
  // ****************************************
  // Configuration store, written by firmware.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        cfgRam_r[i] <= '0;
      end
    end else if (cfgWrEn) begin
      cfgRam_r[cfgWrAddr] <= cfgWrData;
    end
  end

  // Routing picks the configuration and feeds serial inputs.
  always_comb begin
    cfg = cfgRam_r[dpIn[CFG_AW-1:0]];
    set = cfg.regSet;
    unique case (cfg.carrySrc)
      SRC_ZERO:  cin = 1'b0;
      SRC_ROUTE: cin = dpIn[4];
      SRC_CHAIN: cin = chainIn.carry;
      SRC_REG:   cin = carryReg_r[set];
    endcase
    unique case (cfg.shiftSrc)
      SRC_ZERO:  sin = 1'b0;
      SRC_ROUTE: sin = (cfg.shiftOp == SH_RIGHT) ? dpIn[5] : dpIn[3];
      SRC_CHAIN: sin = chainIn.shift;
      SRC_REG:   sin = shiftReg_r[set];
    endcase
  end

  // One ALU shared by both register sets.
  always_comb begin
    unique case (cfg.aluOp)
      ALU_PASS: alu = {1'b0, acc_r[set]};
      ALU_INC:  alu = {1'b0, acc_r[set]} + 9'h001;
      ALU_DEC:  alu = {1'b0, acc_r[set]} - 9'h001;
      ALU_ADD:  alu = {1'b0, acc_r[set]} + {1'b0, data_r[set]} +
                      {8'h00, cin};
      ALU_SUB:  alu = {1'b0, acc_r[set]} - {1'b0, data_r[set]} -
                      {8'h00, cin};
      ALU_AND:  alu = {1'b0, acc_r[set] & data_r[set]};
      ALU_OR:   alu = {1'b0, acc_r[set] | data_r[set]};
      ALU_XOR:  alu = {1'b0, acc_r[set] ^ data_r[set]};
    endcase
    unique case (cfg.shiftOp)
      SH_NONE: begin
        shRes = alu[7:0];
        sout  = 1'b0;
      end
      SH_LEFT: begin
        shRes = {alu[6:0], sin};
        sout  = alu[7];
      end
      SH_RIGHT: begin
        shRes = {sin, alu[7:1]};
        sout  = alu[0];
      end
      SH_SWAP: begin
        shRes = {alu[3:0], alu[7:4]};
        sout  = 1'b0;
      end
    endcase
  end

  // FIFO traffic on the datapath side uses the active set's FIFO.
  always_comb begin
    for (int f = 0; f < 2; f++) begin
      dpPush[f] = subRun[SUB_DP] & cfg.fifoXfer & (set == f[0]) &
                  fifoDirOut[f] & ~fFull[f];
      dpPop[f]  = subRun[SUB_DP] & cfg.fifoXfer & (set == f[0]) &
                  ~fifoDirOut[f] & ~fEmpty[f];
    end
  end

  // Accumulator, data and per-set carry and shift-out registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r      <= '0;
      data_r     <= '0;
      carryReg_r <= 2'h0;
      shiftReg_r <= 2'h0;
    end else if (subRun[SUB_DP]) begin
      if (cfg.accWr) begin
        acc_r[set] <= shRes;
      end
      if (dpPop[set]) begin
        data_r[set] <= fifoHead[set];
      end
      carryReg_r[set] <= alu[8];
      shiftReg_r[set] <= sout;
    end
  end

  // Generated conditions and serial data offered to the outputs.
  always_comb begin
    condVec[0] = (acc_r[set] == data_r[set]) & chainIn.cond;
    condVec[1] = (acc_r[set] == 8'h00);
    condVec[2] = (acc_r[set] == 8'hff);
    condVec[3] = carryReg_r[set];
    condVec[4] = shiftReg_r[set];
    condVec[5] = fEmpty[set];
    condVec[6] = fFull[set];
    condVec[7] = sout;
  end

  // Output selection and chain outputs to the neighbour.
  always_ff @(posedge clk) begin
    if (rst) begin
      dpOut    <= '0;
      chainOut <= '0;
    end else if (subRun[SUB_DP]) begin
      for (int o = 0; o < DP_IO; o++) begin
        dpOut[o] <= condVec[dpOutSel[o]];
      end
      chainOut.cond  <= condVec[0];
      chainOut.carry <= alu[8];
      chainOut.shift <= sout;
    end
  end

  // ****************************************
  // FIFOs
  // ****************************************
  for (genvar f = 0; f < 2; f++) begin : g_fifo
    logic [7:0]         mem_r [FIFO_DEPTH];
    logic [FIFO_AW-1:0] rdPtr_r;
    logic [FIFO_AW-1:0] wrPtr_r;
    logic               push;
    logic               pop;
    logic [7:0]         pushData;

    // Bus feeds an input FIFO; the datapath feeds an output FIFO.
    assign push     = fifoDirOut[f] ? dpPush[f] : (fifoWr[f] & ~fFull[f]);
    assign pop      = fifoDirOut[f] ? (fifoRd[f] & ~fEmpty[f]) : dpPop[f];
    assign pushData = fifoDirOut[f] ? shRes : fifoWrData;
    assign fifoHead[f] = mem_r[rdPtr_r];
    assign fEmpty[f]   = (fifoLevel[f] == '0);
    assign fFull[f]    = (fifoLevel[f] == (FIFO_AW+1)'(FIFO_DEPTH));

    // Storage and pointers.
    always_ff @(posedge clk) begin
      if (rst) begin
        rdPtr_r      <= '0;
        wrPtr_r      <= '0;
        fifoLevel[f] <= '0;
        fifoRdData[f] <= REG_RST;
      end else begin
        if (push) begin
          mem_r[wrPtr_r] <= pushData;
          wrPtr_r        <= wrPtr_r + 1'b1;
        end
        if (pop) begin
          rdPtr_r <= rdPtr_r + 1'b1;
        end
        if (fifoDirOut[f] && pop) begin
          fifoRdData[f] <= fifoHead[f];
        end
        fifoLevel[f] <= fifoLevel[f] + (FIFO_AW+1)'(push) -
                        (FIFO_AW+1)'(pop);
      end
    end
  end

  // ****************************************
  // Product term arrays and requests
  // ****************************************
  // Two small arrays: OR of two masked AND terms, registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      ptaOut <= 2'h0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        if (subRun[a]) begin
          ptaOut[a] <= (&(routeIn | ~ptaMask[a][0]) & |ptaMask[a][0]) |
                       (&(routeIn | ~ptaMask[a][1]) & |ptaMask[a][1]);
        end
      end
    end
  end

  // Any pooled signal may drive any interrupt or DMA request.
  always_ff @(posedge clk) begin
    if (rst) begin
      irqReq <= '0;
      dmaReq <= '0;
    end else begin
      for (int k = 0; k < NREQ; k++) begin
        irqReq[k] <= pool[irqSel[k]];
        dmaReq[k] <= pool[dmaSel[k]];
      end
    end
  end

  // ****************************************
  // I/O port routing
  // ****************************************
  for (genvar p = 0; p < PIN_N; p++) begin : g_pin
    logic outSync_r;
    logic inMeta_r;
    logic inSync_r;
    logic oe;

    // Synchronising stages on the system clock.
    always_ff @(posedge clk) begin
      if (rst) begin
        outSync_r <= 1'b0;
        inMeta_r  <= 1'b0;
        inSync_r  <= 1'b0;
      end else begin
        outSync_r <= ioOutRoute[p];
        inMeta_r  <= pinIn[p];
        inSync_r  <= inMeta_r;
      end
    end

    // Enable grouping from all eight ganged down to four single pins.
    always_comb begin
      unique case (oeMode)
        OE_GANG8: oe = ioOeRoute[0];
        OE_PAIRS: oe = ioOeRoute[p/2];
        OE_FOUR:  oe = (p < OE_N) ? ioOeRoute[p % OE_N] : 1'b1;
        OE_NONE:  oe = 1'b1;
      endcase
    end

    // Deselected stages are bypassed with no added cycles.
    assign pinOut[p]    = ioOutSyncEn[p] ? outSync_r : ioOutRoute[p];
    assign ioInRoute[p] = ioInSyncEn[p] ? inSync_r : pinIn[p];
    assign pinOeN[p]    = ~oe;
  end

endmodule

`default_nettype wire

// >>> verification/lbcsr_pin_pad.sv
// Purpose: Pad model for the eight routed pins of one port.
// Assumes: No pull resistor is fitted on any pad.
// Notes:   An undriven pad flips every cycle.
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Pad model
// ****************************************
module lbcsr_pin_pad (
  input  wire logic       clk,    // System clock.
  input  wire logic [7:0] pinOut, // Device drive.
  input  wire logic [7:0] pinOeN, // Low drives.
  input  wire logic [7:0] ext,    // Outside level.
  input  wire logic       extEn,  // Outside drives.
  output logic      [7:0] pinIn   // Pad level.
);
  // Starts from a known level so a floating pad never shows unknowns.
  logic [7:0] last_r = 8'h00;

  // Device drive wins, then outside drive, else the pad floats and flips.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pinOeN[i]) begin
        pinIn[i] = pinOut[i];
      end else if (extEn) begin
        pinIn[i] = ext[i];
      end else begin
        pinIn[i] = ~last_r[i];
      end
    end
  end

  // Remembers the level shown so a float never repeats it.
  always_ff @(posedge clk) begin
    last_r <= pinIn;
  end
endmodule
`default_nettype wire

// >>> verification/lbcsr_top_chk.sv
// Purpose: Port checker for the logic block routing core.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Pin 0 and request 0 stand for their peers.
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Checker
// ****************************************
module lbcsr_top_chk
  import lbcsr_pkg::*;
#(
  parameter int NREQ = 4
) (
  input wire logic                           clk,         // Clock.
  input wire logic                           rst,         // Reset.
  input wire logic                           ctrlWrEn,    // Write.
  input wire logic [7:0]                     ctrlWrData,  // Data.
  input wire logic [7:0]                     ctrlRouteEn, // Routed.
  input wire logic [7:0]                     ctrlOut,     // Control.
  input wire logic                           stsRdEn,     // Read.
  input wire logic [7:0]                     stsSticky,   // Hold.
  input wire logic [7:0][POOL_SELW-1:0]      stsSel,      // Source.
  input wire logic [7:0]                     stsRdData,   // Status.
  input wire logic [ROUTE_W-1:0]             routeIn,     // Routing.
  input wire logic [SUB_N-1:0][1:0]          subEnMode,   // Enables.
  input wire logic [NREQ-1:0][POOL_SELW-1:0] irqSel,      // Source.
  input wire logic [NREQ-1:0]                irqReq,      // Request.
  input wire logic [PIN_N-1:0]               ioOutRoute,  // Pin data.
  input wire logic [OE_N-1:0]                ioOeRoute,   // Enables.
  input wire logic [PIN_N-1:0]               ioInRoute,   // Pin read.
  input wire logic [PIN_N-1:0]               ioOutSyncEn, // Out sync.
  input wire logic [PIN_N-1:0]               ioInSyncEn,  // In sync.
  input wire logic [1:0]                     oeMode,      // Grouping.
  input wire logic [PIN_N-1:0]               pinIn,       // Pad.
  input wire logic [PIN_N-1:0]               pinOut,      // Drive.
  input wire logic [PIN_N-1:0]               pinOeN       // Low drives.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic scRun;

  // Status and control unit is clocked.
  assign scRun = (subEnMode[SUB_SC] == EN_RUN);

  a_ctrl_path: assert property (
    ctrlWrEn && scRun ##1 scRun |=>
    ctrlOut == ($past(ctrlWrData, 2) & $past(ctrlRouteEn)))
    else $error("control byte not routed");
  a_ctrl_frozen: assert property (
    subEnMode[SUB_SC] == EN_STOP |=> $stable(ctrlOut))
    else $error("control moved while stopped");
  a_sts_live: assert property (
    stsRdEn && scRun && !stsSticky[0] && stsSel[0] < 4'h8 |=>
    stsRdData[0] == $past(routeIn[stsSel[0][2:0]]))
    else $error("status read not live");
  a_sts_hold: assert property (
    scRun && stsSticky[1] && stsSel[1] < 4'h8
    && routeIn[stsSel[1][2:0]] ##1 scRun && !stsRdEn && stsSticky[1]
    ##1 scRun && stsRdEn && stsSticky[1] |=> stsRdData[1])
    else $error("held status lost");
  a_sts_stands: assert property (
    !stsRdEn |=> $stable(stsRdData))
    else $error("status data moved");
  a_out_bypass: assert property (
    !ioOutSyncEn[0] |-> pinOut[0] == ioOutRoute[0])
    else $error("output bypass delayed");
  a_out_sync: assert property (
    ioOutSyncEn[0] ##1 ioOutSyncEn[0] |-> pinOut[0] == $past(ioOutRoute[0]))
    else $error("output stage wrong");
  a_in_sync: assert property (
    ioInSyncEn[0] [*3] |-> ioInRoute[0] == $past(pinIn[0], 2))
    else $error("input stages wrong");
  a_in_bypass: assert property (
    !ioInSyncEn[0] |-> ioInRoute[0] == pinIn[0])
    else $error("input bypass delayed");
  a_oe_gang: assert property (
    oeMode == OE_GANG8 |-> pinOeN == {8{~ioOeRoute[0]}})
    else $error("ganged enable wrong");
  a_irq_route: assert property (
    irqSel[0] < 4'h8 |=> irqReq[0] == $past(routeIn[irqSel[0][2:0]]))
    else $error("request not routed");
endmodule

bind lbcsr_top lbcsr_top_chk #(.NREQ(NREQ)) chk_u (.clk, .rst, .ctrlWrEn,
  .ctrlWrData, .ctrlRouteEn, .ctrlOut, .stsRdEn, .stsSticky, .stsSel,
  .stsRdData, .routeIn, .subEnMode, .irqSel, .irqReq, .ioOutRoute,
  .ioOeRoute, .ioInRoute, .ioOutSyncEn, .ioInSyncEn, .oeMode, .pinIn,
  .pinOut, .pinOeN);
`default_nettype wire

// >>> verification/lbcsr_top_bench.sv
// Purpose: Self-checking bench for the logic block routing core.
// Assumes: Pads are modelled by lbcsr_pin_pad.
// Notes:   Each t_ctrl to t_fifo task drives one scenario and judges it; cyc, chk, rd and wrap_up are helpers.
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Bench
// ****************************************
module lbcsr_top_bench;
  import lbcsr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, extEn = 1'b0;
  logic ctrlWrEn = 1'b0, stsRdEn = 1'b0, cfgWrEn = 1'b0;
  logic [7:0] ctrlWrData = 8'h00, ctrlRouteEn = 8'h00, stsSticky = 8'h00;
  logic [7:0] routeIn = 8'h00, fifoWrData = 8'h00, ext = 8'h00;
  logic [7:0] ioOutRoute = 8'h00, ioOutSyncEn = 8'h00, ioInSyncEn = 8'h00;
  logic [7:0][POOL_SELW-1:0] stsSel = '0;
  logic [3:0][POOL_SELW-1:0] irqSel = '0, dmaSel = '0;
  logic [CFG_AW-1:0] cfgWrAddr = '0;
  lbcsr_cfg_t cfgWrData = '0;
  lbcsr_chain_t chainIn = '0, chainOut;
  logic [DP_IO-1:0] dpIn = '0, dpOut;
  logic [DP_IO-1:0][2:0] dpOutSel = '0;
  logic [1:0] fifoDirOut = 2'h0, fifoWr = 2'h0, fifoRd = 2'h0;
  logic [1:0] oeMode = 2'h0, ptaOut;
  logic [SUB_N-1:0][1:0] subEnMode = {SUB_N{EN_RUN}};
  logic [1:0][1:0][ROUTE_W-1:0] ptaMask = '0;
  logic [3:0] ioOeRoute = 4'h0, irqReq, dmaReq;
  logic [7:0] ctrlOut, stsRdData, ioInRoute, pinIn, pinOut, pinOeN;
  logic [1:0][7:0] fifoRdData;
  logic [1:0][FIFO_AW:0] fifoLevel;
  int n_mismatch = 0, total_checks = 0, cycles = 0;

  lbcsr_top #(.NREQ(4)) dut_u (.clk, .rst, .ctrlWrEn, .ctrlWrData,
    .ctrlRouteEn, .ctrlOut, .stsRdEn, .stsSticky, .stsSel, .stsRdData,
    .routeIn, .cfgWrEn, .cfgWrAddr, .cfgWrData, .dpIn, .dpOutSel, .dpOut,
    .chainIn, .chainOut, .fifoDirOut, .fifoWr, .fifoWrData, .fifoRd,
    .fifoRdData, .fifoLevel, .subEnMode, .ptaMask, .ptaOut, .irqSel,
    .irqReq, .dmaSel, .dmaReq, .ioOutRoute, .ioOeRoute, .ioInRoute,
    .ioOutSyncEn, .ioInSyncEn, .oeMode, .pinIn, .pinOut, .pinOeN);
  lbcsr_pin_pad pad_u (.clk, .pinOut, .pinOeN, .ext, .extEn, .pinIn);

  // Clock, and a cycle ceiling that cuts a hang short.
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 600) begin
      n_mismatch++;
      wrap_up;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Expected enables: low means the pin is driven.
  function automatic logic [7:0] oeExp(input logic [1:0] m,
                                       input logic [3:0] oe);
    logic [7:0] r;
    for (int p = 0; p < 8; p++) begin
      case (m)
        OE_GANG8: r[p] = ~oe[0];
        OE_PAIRS: r[p] = ~oe[p/2];
        OE_FOUR:  r[p] = (p < 4) ? ~oe[p[1:0]] : 1'b0;
        default:  r[p] = 1'b0;
      endcase
    end
    return r;
  endfunction

  task automatic t_ctrl;
    @(posedge clk);
    ctrlRouteEn <= 8'h0f;
    ctrlWrData <= 8'ha5;
    ctrlWrEn <= 1'b1;
    @(posedge clk);
    ctrlWrEn <= 1'b0;
    @(posedge clk);
    #1 chk("ctrlOut", 8'h05, ctrlOut);
    @(posedge clk);
    subEnMode[SUB_SC] <= EN_STOP;
    ctrlWrData <= 8'h3c;
    ctrlWrEn <= 1'b1;
    @(posedge clk);
    ctrlWrEn <= 1'b0;
    cyc(2);
    #1 chk("ctrlOut stopped", 8'h05, ctrlOut);
    @(posedge clk);
    subEnMode[SUB_SC] <= EN_RUN;
    $display("control test done");
  endtask

  task automatic rd(input logic [7:0] e);
    @(posedge clk);
    stsRdEn <= 1'b1;
    @(posedge clk);
    stsRdEn <= 1'b0;
    #1 chk("stsRdData", e, stsRdData);
  endtask

  task automatic t_sts;
    @(posedge clk);
    stsSticky <= 8'h02;
    stsSel[0] <= 4'h3;
    stsSel[1] <= 4'h2;
    routeIn <= 8'h0c;
    @(posedge clk);
    routeIn <= 8'h08;
    @(posedge clk);
    rd(8'h03);
    rd(8'h01);
    $display("status test done");
  endtask

  task automatic t_dp;
    @(posedge clk);
    cfgWrEn <= 1'b1;
    cfgWrAddr <= 3'h1;
    cfgWrData <= '{aluOp: ALU_INC, accWr: 1'b1, default: '0};
    dpOutSel[0] <= 3'h1;
    dpOutSel[1] <= 3'h2;
    @(posedge clk);
    cfgWrEn <= 1'b0;
    cyc(2);
    #1 chk("dpOut", 8'h01, {2'h0, dpOut} & 8'h03);
    @(posedge clk);
    dpIn <= 6'h01;
    @(posedge clk);
    dpIn <= 6'h00;
    cyc(2);
    #1 chk("dpOut", 8'h00, {2'h0, dpOut} & 8'h03);
    $display("datapath test done");
  endtask

  task automatic t_pins;
    @(posedge clk);
    oeMode <= OE_NONE;
    ioOutSyncEn <= 8'h0f;
    ioOutRoute <= 8'h5a;
    #1 chk("pinOut", 8'h50, pinOut & 8'hf0);
    @(posedge clk);
    #1 chk("pinOut", 8'h5a, pinOut);
    chk("ioInRoute", 8'h5a, ioInRoute);
    @(posedge clk);
    oeMode <= OE_GANG8;
    ioInSyncEn <= 8'hf0;
    extEn <= 1'b1;
    cyc(3);
    ext <= 8'h3c;
    #1 chk("ioInRoute", 8'h0c, ioInRoute);
    @(posedge clk);
    #1 chk("ioInRoute", 8'h0c, ioInRoute);
    @(posedge clk);
    #1 chk("ioInRoute", 8'h3c, ioInRoute);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      oeMode <= m[1:0];
      ioOeRoute <= 4'ha;
      #1 chk("pinOeN", oeExp(m[1:0], 4'ha), pinOeN);
    end
    $display("pin test done");
  endtask

  task automatic t_req;
    @(posedge clk);
    irqSel[0] <= 4'h3;
    dmaSel[1] <= 4'h5;
    routeIn <= 8'h28;
    ptaMask[0][0] <= 8'h28;
    @(posedge clk);
    #1 chk("irqReq", 8'h01, {4'h0, irqReq});
    chk("ptaOut", 8'h01, {6'h00, ptaOut});
    chk("dmaReq", 8'h02, {4'h0, dmaReq});
    $display("request test done");
  endtask

  task automatic t_fifo;
    @(posedge clk);
    subEnMode[SUB_DP] <= EN_STOP;
    fifoWrData <= 8'h11;
    fifoWr <= 2'b01;
    cyc(5);
    fifoWr <= 2'b00;
    #1 chk("fifoLevel", 8'h04, {5'h0, fifoLevel[0]});
    $display("fifo test done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Reset, then each scenario in turn.
  initial begin
    cyc(12);
    rst <= 1'b0;
    t_ctrl;
    t_sts;
    t_dp;
    t_pins;
    t_req;
    t_fifo;
    wrap_up;
  end
endmodule
`default_nettype wire
